/* kms_pkg.sv */
// Package: register map, field positions and sequencer states of the key matrix scan control
package kms_pkg;
    localparam int COLS = 16;
    localparam int CFG_W = 8;
    // APB register offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_SRCDATA = 8'h10;
    localparam logic [7:0] OFS_TIMING = 8'h14;
    // Configuration fields
    localparam int CFG_B7 = 7;
    localparam int CFG_B6 = 6;
    localparam int CFG_B5 = 5;
    localparam int CFG_B4 = 4;
    localparam int CFG_B3 = 3;
    localparam int CFG_B2 = 2;
    localparam int CFG_B1 = 1;
    // Command register bits
    localparam int CMD_IMM = 0;
    localparam int CMD_REG = 1;
    localparam int CMD_TAB = 2;
    // Control/status bits
    localparam int ST_HRQ = 0;
    localparam int ST_KSF = 1;
    localparam int ST_W = 2;
    localparam int TIM_HEN = 16;
    localparam logic [7:0] CFG_RST = 8'h40;
    localparam logic [15:0] INTERVAL_RST = 16'h0100;
    localparam logic [15:0] COLS_NONE = 16'h0000;
    localparam logic [15:0] COLS_ALL = 16'hFFFF;
    localparam logic [31:0] ERR_VAL = 32'h0000_0000;
    typedef enum logic [2:0] {
        SM_LCD = 3'b001,
        SM_SCAN = 3'b010,
        SM_DONE = 3'b100
    } kms_state_type;
endpackage

/* kms_cfg_if.sv */
// Interface: configuration word and decoded column select between top and decoder
`timescale 1ns/10ps
interface kms_cfg_if;
    logic [7:0] cfg;
    logic [15:0] cols;
    logic scan_off;
    modport owner (output cfg, input cols, input scan_off);
    modport decoder (input cfg, output cols, output scan_off);
endinterface

/* kms_decode.sv */
// Scan configuration decoder: turns the eight-bit setting into active columns
`timescale 1ns/10ps
module kms_decode (
    kms_cfg_if.decoder d
);
    import kms_pkg::*;

    function automatic logic [15:0] group_mask(input logic [3:0] idx, input int size);
        logic [15:0] base;
        base = COLS_NONE;
        for (int i = 0; i < COLS; i++) begin
            if ((i / size) == (int'(idx) / size)) begin
                base[i] = 1'b1;
            end
        end
        return base;
    endfunction

    always_comb begin
        logic [2:0] sel;
        sel = {d.cfg[CFG_B7], d.cfg[CFG_B5], d.cfg[CFG_B4]};
        d.scan_off = 1'b0;
        d.cols = COLS_NONE;
        if (sel == 3'h0) begin
            d.cols = group_mask(d.cfg[3:0], 1);
        end else if (sel == 3'h1) begin
            d.cols = COLS_ALL;
        end else if (sel[2:1] == 2'h1) begin
            d.scan_off = 1'b1;
        end else if (sel[2:1] == 2'h2) begin
            d.cols = group_mask({d.cfg[CFG_B3], 3'h0}, 8);
        end else if (sel == 3'h6) begin
            d.cols = group_mask({d.cfg[CFG_B3], d.cfg[CFG_B2], 2'h0}, 4);
        end else begin
            d.cols = group_mask({d.cfg[3:1], 1'b0}, 2);
        end
    end
endmodule

/* kms_top.sv */
// Key matrix scan control: configuration, scan sequencing and halt-release flags
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - Drive scan state on the sixteen shared pins during scan interval, else LCD data.
// - Bit 6 clear with enable: request flag on key press, then status flag.
// - Bit 6 set with enable: request flag after every scan cycle, then status flag.
// - Mode 000 scans one column indexed by bits 3..0.
// - Mode 001 scans all sixteen columns; bits 3..0 ignored.
// - Mode 01x disables scanning; bits 3..0 ignored.
// - Mode 10x scans eight columns chosen by bit 3.
// - Mode 110 scans four columns chosen by bits 3..2.
// - Mode 111 scans two adjacent columns chosen by bits 3..1.
// - Register form: accumulator nibble high, working register nibble low.
// - Table form: table word at index pointer taken bit for bit.
module kms_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] acc_nibble,
    input wire logic [3:0] work_reg_nibble,
    input wire logic [7:0] table_rom_word,
    output logic [11:0] index_pointer,
    input wire logic [15:0] lcd_segment_data,
    input wire logic [3:0] key_return_pins,
    output logic [15:0] shared_segment_pins,
    output logic scan_active,
    output logic halt_release_request_key,
    output logic key_status_flag,
    output logic irq
);
    import kms_pkg::*;

    kms_cfg_if cif ();
    kms_decode u_dec (.d(cif));

    logic [7:0] cfg_r, cfg_nxt;
    logic [11:0] idx_r, idx_nxt;
    logic [15:0] ivl_r, ivl_nxt;
    logic hen_r, hen_nxt;
    logic [ST_W-1:0] st_r, st_nxt, mask_r, mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    kms_state_type sm_r, sm_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] seg_r, seg_nxt;
    logic [3:0] key_s1_r, key_s2_r;
    logic press_r, press_nxt;

    assign cif.cfg = cfg_r;

    // APB decode
    logic wr_en, rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a == OFS_CFG) || (a == OFS_CMD) || (a == OFS_STATUS) || (a == OFS_MASK)
            || (a == OFS_SRCDATA) || (a == OFS_TIMING);
    endfunction

    assign pslverr = psel && penable && !addr_ok(paddr);

    // Register group: config, timing, index pointer, mask, read data
    always_comb begin
        cfg_nxt = cfg_r;
        idx_nxt = idx_r;
        ivl_nxt = ivl_r;
        hen_nxt = hen_r;
        mask_nxt = mask_r;
        prdata_nxt = prdata_r;
        if (wr_en) begin
            if (paddr == OFS_CFG) begin
                cfg_nxt = pwdata[7:0];
            end else if (paddr == OFS_CMD) begin
                if (pwdata[CMD_REG]) begin
                    cfg_nxt = {acc_nibble, work_reg_nibble};
                end else if (pwdata[CMD_TAB]) begin
                    cfg_nxt = table_rom_word;
                end else if (pwdata[CMD_IMM]) begin
                    cfg_nxt = pwdata[15:8];
                end
            end else if (paddr == OFS_MASK) begin
                mask_nxt = pwdata[ST_W-1:0];
            end else if (paddr == OFS_SRCDATA) begin
                idx_nxt = pwdata[11:0];
            end else if (paddr == OFS_TIMING) begin
                ivl_nxt = pwdata[15:0];
                hen_nxt = pwdata[TIM_HEN];
            end
        end
        if (rd_en) begin
            if (paddr == OFS_CFG) begin
                prdata_nxt = {24'h000000, cfg_r};
            end else if (paddr == OFS_CMD) begin
                prdata_nxt = {29'h0, sm_r};
            end else if (paddr == OFS_STATUS) begin
                prdata_nxt = {30'h0, st_r};
            end else if (paddr == OFS_MASK) begin
                prdata_nxt = {30'h0, mask_r};
            end else if (paddr == OFS_SRCDATA) begin
                prdata_nxt = {20'h00000, idx_r};
            end else if (paddr == OFS_TIMING) begin
                prdata_nxt = {15'h0000, hen_r, ivl_r};
            end else begin
                prdata_nxt = ERR_VAL;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= CFG_RST;
            idx_r <= 12'h000;
            ivl_r <= INTERVAL_RST;
            hen_r <= 1'b0;
            mask_r <= 2'h0;
            prdata_r <= 32'h0000_0000;
        end else begin
            cfg_r <= cfg_nxt;
            idx_r <= idx_nxt;
            ivl_r <= ivl_nxt;
            hen_r <= hen_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Read data would land one cycle late in the register, so during the access it is presented from the next value
    assign prdata = rd_en ? prdata_nxt : prdata_r;
    assign index_pointer = idx_r;

    // Return lines come from pins; two flops before use
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key_s1_r <= 4'h0;
            key_s2_r <= 4'h0;
        end else begin
            key_s1_r <= key_return_pins;
            key_s2_r <= key_s1_r;
        end
    end

    // Scan sequencer: LCD phase, scan interval, end of cycle
    logic cycle_end;
    always_comb begin
        sm_nxt = sm_r;
        cnt_nxt = cnt_r + 16'h0001;
        seg_nxt = lcd_segment_data;
        press_nxt = press_r;
        cycle_end = 1'b0;
        case (sm_r)
            SM_LCD: begin
                if (cnt_r >= ivl_r) begin
                    cnt_nxt = 16'h0000;
                    if (!cif.scan_off) begin
                        sm_nxt = SM_SCAN;
                        press_nxt = 1'b0;
                        // Columns go out together with the scan state, so no LCD data is seen as keys
                        seg_nxt = cif.cols;
                    end
                end
            end
            SM_SCAN: begin
                seg_nxt = cif.cols;
                if (|key_s2_r) begin
                    press_nxt = 1'b1;
                end
                if (cnt_r >= ivl_r) begin
                    cnt_nxt = 16'h0000;
                    sm_nxt = SM_DONE;
                    seg_nxt = lcd_segment_data;
                end
            end
            SM_DONE: begin
                cycle_end = 1'b1;
                cnt_nxt = 16'h0000;
                sm_nxt = SM_LCD;
            end
            default: begin
                sm_nxt = SM_LCD;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sm_r <= SM_LCD;
            cnt_r <= 16'h0000;
            seg_r <= 16'h0000;
            press_r <= 1'b0;
        end else begin
            sm_r <= sm_nxt;
            cnt_r <= cnt_nxt;
            seg_r <= seg_nxt;
            press_r <= press_nxt;
        end
    end

    // Flags: request first, status one cycle after; set wins over clear
    logic hrq_set, ksf_set_r, ksf_set_nxt;
    always_comb begin
        hrq_set = 1'b0;
        if (cycle_end && hen_r) begin
            if (cfg_r[CFG_B6]) begin
                hrq_set = 1'b1;
            end else begin
                hrq_set = press_r;
            end
        end
        ksf_set_nxt = hrq_set;
        st_nxt = st_r;
        if (wr_en && paddr == OFS_STATUS) begin
            st_nxt = st_r & ~pwdata[ST_W-1:0];
        end
        if (hrq_set) begin
            st_nxt[ST_HRQ] = 1'b1;
        end
        if (ksf_set_r) begin
            st_nxt[ST_KSF] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= 2'h0;
            ksf_set_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ksf_set_r <= ksf_set_nxt;
        end
    end

    assign shared_segment_pins = seg_r;
    assign scan_active = (sm_r == SM_SCAN);
    assign halt_release_request_key = st_r[ST_HRQ];
    assign key_status_flag = st_r[ST_KSF];
    assign irq = |(st_r & mask_r);
endmodule

/* kms_keys.sv */
// Model of the key switch matrix behind the shared segment pins
`timescale 1ns/10ps
module kms_keys (
    input wire logic [15:0] shared_segment_pins,
    input wire logic scan_active,
    input wire logic key_down,
    input wire logic [3:0] key_col,
    input wire logic [1:0] key_row,
    output logic [3:0] key_return_pins
);
    // Return lines are pulled low, so an unscanned column reads 0
    always_comb begin
        key_return_pins = 4'h0;
        if (key_down && scan_active && shared_segment_pins[key_col]) begin
            key_return_pins[key_row] = 1'b1;
        end
    end
endmodule

/* kms_top_properties.sv */
// Checker: port-level properties of the key scan control
`timescale 1ns/10ps
module kms_top_properties (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] lcd_segment_data,
    input wire logic [15:0] shared_segment_pins,
    input wire logic scan_active,
    input wire logic halt_release_request_key,
    input wire logic key_status_flag,
    input wire logic irq
);
    import kms_pkg::*;
    wire acs = psel && penable;
    wire clr = acs && pwrite && paddr == OFS_STATUS;
    wire hrq = halt_release_request_key;
    wire ksf = key_status_flag;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_zero_wait: assert property (acs |-> pready)
        else $error("wait state");
    a_bad_address: assert property (acs && paddr > OFS_TIMING |-> pslverr)
        else $error("no error on unmapped");
    a_error_zero: assert property (acs && !pwrite && pslverr |-> prdata == ERR_VAL)
        else $error("error read not zero");
    a_status_follows: assert property ($rose(hrq) |=> ksf)
        else $error("status flag late");
    a_request_sticky: assert property (hrq && !(clr && pwdata[ST_HRQ]) |=> hrq)
        else $error("request flag lost");
    a_status_sticky: assert property (ksf && !(clr && pwdata[ST_KSF]) |=> ksf)
        else $error("status flag lost");
    a_request_scan: assert property ($rose(hrq) |->
        $past(scan_active) || $past(scan_active, 2)) else $error("request without scan");
    a_irq_quiet: assert property (!hrq && !ksf |-> !irq)
        else $error("irq without flag");
    // The first cycle after a scan already shows LCD data again; it is left out of the check
    a_lcd_idle: assert property (!scan_active && !$past(scan_active) && !$past(rst) |->
        shared_segment_pins == $past(lcd_segment_data)) else $error("lcd data lost");
endmodule
bind kms_top kms_top_properties kms_top_properties_i (.*);

/* testbench.sv */
// Bench: APB traffic, scan modes and wake-up flags
`timescale 1ns/10ps
module testbench;
    import kms_pkg::*;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, scan_active, irq, key_down;
    logic halt_release_request_key, key_status_flag, scan_d, seen;
    logic [7:0] paddr, table_rom_word;
    logic [31:0] pwdata, prdata;
    logic [3:0] acc_nibble, work_reg_nibble, key_col, key_return_pins;
    logic [15:0] lcd_segment_data, shared_segment_pins;
    logic [11:0] index_pointer;
    logic [1:0] key_row;
    logic [31:0] rq[$];
    logic [15:0] sq[$];
    int fail_count, n_compared;
    logic [7:0] cfgs[8] = '{8'h40, 8'h1F, 8'h80, 8'h98, 8'hA4, 8'hAC, 8'hF1, 8'hFE};
    logic [15:0] masks[8] = '{16'h0001, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h00F0, 16'hF000,
        16'h0003, 16'hC000};
    kms_top kms_top_i (.*);
    kms_keys kms_keys_i (.*);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bail(input int k);
        if (k >= 100) begin
            fail_count++;
            end_sim;
        end
    endtask
    // A read queues its expected word; the monitor checks it at the access edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        if (!w) rq.push_back(d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 100);
        bail(k);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task wait_lvl(input logic v);
        int k;
        k = 0;
        while (scan_active !== v && k < 100) begin
            @(posedge clock);
            k++;
        end
        bail(k);
    endtask
    task scan_mask(input logic [7:0] c, input logic [15:0] m);
        apb(1'b1, OFS_CFG, {24'h0, c});
        wait_lvl(1'b0);
        sq.push_back(m);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        cmp(sq.size(), 0);
    endtask
    always @(posedge clock) begin
        scan_d <= scan_active;
        if (psel && penable && pready && !pwrite) begin
            cmp(prdata, rq.pop_front());
        end
        if (sq.size() > 0 && scan_active && scan_d) begin
            cmp(shared_segment_pins, sq.pop_front());
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, key_down, paddr, pwdata} = '0;
        {acc_nibble, work_reg_nibble, key_col, key_row} = '0;
        void'($urandom(32'h0D13BBBC));
        lcd_segment_data = 16'($urandom);
        table_rom_word = 8'($urandom);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, OFS_CFG, {24'h0, CFG_RST});
        apb(1'b0, 8'h18, ERR_VAL);
        apb(1'b1, OFS_TIMING, 32'h0001_0004);
        apb(1'b0, OFS_TIMING, 32'h0001_0004);
        apb(1'b1, OFS_MASK, 32'h3);
        key_col <= 4'($urandom);
        acc_nibble <= 4'($urandom);
        work_reg_nibble <= 4'($urandom);
        @(posedge clock);
        cfgs[0] = {4'h4, key_col};
        masks[0] = 16'h1 << key_col;
        for (int i = 0; i < 8; i++) begin
            scan_mask(cfgs[i], masks[i]);
        end
        apb(1'b1, OFS_CFG, 32'h20);
        wait_lvl(1'b0);
        seen = 1'b0;
        repeat (30) begin
            @(posedge clock);
            seen = seen | scan_active;
        end
        cmp(seen, 0);
        cmp(shared_segment_pins, lcd_segment_data);
        apb(1'b1, OFS_SRCDATA, 32'h2C3);
        cmp(index_pointer, 32'h2C3);
        apb(1'b1, OFS_CMD, 32'h2);
        apb(1'b0, OFS_CFG, {acc_nibble, work_reg_nibble});
        apb(1'b1, OFS_CMD, 32'h4);
        apb(1'b0, OFS_CFG, table_rom_word);
        apb(1'b1, OFS_CMD, 32'hA501);
        apb(1'b0, OFS_CFG, 32'hA5);
        apb(1'b1, OFS_STATUS, 32'h3);
        apb(1'b1, OFS_CFG, 32'h5F);
        repeat (30) @(posedge clock);
        apb(1'b0, OFS_STATUS, 32'h3);
        cmp(irq, 1);
        apb(1'b1, OFS_CFG, 32'h1F);
        apb(1'b0, OFS_STATUS, 32'h3);
        apb(1'b1, OFS_STATUS, 32'h3);
        repeat (30) @(posedge clock);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp(irq, 0);
        key_row <= 2'h2;
        key_down <= 1'b1;
        repeat (30) @(posedge clock);
        apb(1'b0, OFS_STATUS, 32'h3);
        apb(1'b1, OFS_MASK, 32'h0);
        cmp(irq, 0);
        end_sim;
    end
endmodule
